// ==== hdl/cifl_core.sv ====
// Codec interrupt flags, masks and interrupt output pulses
`timescale 1ns/1ns

// How it works
// - Left short bit reads 1 while a left driver short is present, resets 0
// - Right short bit reads 1 while a right driver short is present, resets 0
// - Button bit reads 1 while the headset button is pressed
// - Headset bit reads 1 for insertion, 0 for removal
// - Left power bit reads 1 while left power is above compressor threshold
// - Right power bit reads 1 while right power is above compressor threshold
// - Noise bit reads 1 while record power is below noise threshold
// - Record register shows a read-only DC measurement available bit
// - First output masks insertion, button and power events by bits 7, 6, 5
// - First output masks noise, short and DC events by bits 4, 3, 1
// - Second output has its own masks for insertion, button and power
// - Second output has its own masks for noise, short and DC events
// - First output bit 0 picks one 2 ms pulse or pulses every 4 ms
// - Second output bit 0 picks the same single or repeated pulses
// - Repeated pulses stop once both sticky registers have been read
// - Sticky bits clear on read but set again while their source stays active; headset only on a change
module cifl_core #(
    parameter int CYCLES_PER_TICK = cifl_pkg::CYCLES_PER_TICK
) (
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic [7:0]      reg_rdata_out,
    input  wire logic       short_left_in,
    input  wire logic       short_right_in,
    input  wire logic       button_in,
    input  wire logic       headset_in,
    input  wire logic       power_left_in,
    input  wire logic       power_right_in,
    input  wire logic       noise_low_in,
    input  wire logic       dc_avail_in,
    output logic            first_irq_output_out,
    output logic            second_irq_output_out
);
    // Mask decode shared by both outputs
    function automatic logic masked_any(input logic [7:0] mask, input logic [7:0] events);
        masked_any = |(mask & events);
    endfunction

    logic [7:0] first_irq_mask_control;
    logic [7:0] second_irq_mask_control;
    logic [7:0] record_rsvd;
    logic [7:0] play_sticky;
    logic [7:0] rec_sticky;
    logic [7:0] prev_src;
    logic       read_play_seen;
    logic       read_rec_seen;

    logic [7:0] src;
    logic [7:0] src_rise;
    logic       headset_change;
    logic [7:0] playback_event_status;
    logic [7:0] record_event_status;
    logic [7:0] play_set;
    logic [7:0] rec_set;
    logic [7:0] events;
    logic       sel_play_sticky;
    logic       sel_rec_sticky;
    logic       sel_rec_status;
    logic       sel_ctrl1;
    logic       sel_ctrl2;
    logic       rd_play_sticky;
    logic       rd_rec_sticky;
    logic       both_read;
    logic       trigger1;
    logic       trigger2;
    logic       tick;
    logic [7:0] next_rdata;
    logic [7:0] next_play_sticky;
    logic [7:0] next_rec_sticky;

    // Source levels packed in playback layout, record sources in free bits
    assign src = {short_left_in, short_right_in, button_in, headset_in,
                  power_left_in, power_right_in, noise_low_in, dc_avail_in};
    assign src_rise       = src & ~prev_src;
    assign headset_change = src[cifl_pkg::BIT_HEADSET] ^ prev_src[cifl_pkg::BIT_HEADSET];

    // Live status views
    always_comb begin
        playback_event_status = 8'h00;
        playback_event_status[cifl_pkg::BIT_SHORT_LEFT]  = short_left_in;
        playback_event_status[cifl_pkg::BIT_SHORT_RIGHT] = short_right_in;
        playback_event_status[cifl_pkg::BIT_BUTTON]      = button_in;
        playback_event_status[cifl_pkg::BIT_HEADSET]     = headset_in;
        playback_event_status[cifl_pkg::BIT_POWER_LEFT]  = power_left_in;
        playback_event_status[cifl_pkg::BIT_POWER_RIGHT] = power_right_in;
    end

    always_comb begin
        record_event_status = record_rsvd & cifl_pkg::REC_WR_MASK;
        record_event_status[cifl_pkg::BIT_NOISE]    = noise_low_in;
        record_event_status[cifl_pkg::BIT_DC_AVAIL] = dc_avail_in;
    end

    // Sticky set terms; the headset flag catches both insertion and removal
    always_comb begin
        play_set = playback_event_status;
        play_set[cifl_pkg::BIT_HEADSET] = headset_change;
        rec_set  = 8'h00;
        rec_set[cifl_pkg::BIT_NOISE]    = noise_low_in;
        rec_set[cifl_pkg::BIT_DC_AVAIL] = dc_avail_in;
    end

    // Event vector in mask bit layout
    always_comb begin
        events = 8'h00;
        events[cifl_pkg::BIT_M_INSERT] = headset_change;
        events[cifl_pkg::BIT_M_BUTTON] = src_rise[cifl_pkg::BIT_BUTTON];
        events[cifl_pkg::BIT_M_POWER]  = src_rise[cifl_pkg::BIT_POWER_LEFT]
                                       | src_rise[cifl_pkg::BIT_POWER_RIGHT];
        events[cifl_pkg::BIT_M_NOISE]  = src_rise[1];
        events[cifl_pkg::BIT_M_SHORT]  = src_rise[cifl_pkg::BIT_SHORT_LEFT]
                                       | src_rise[cifl_pkg::BIT_SHORT_RIGHT];
        events[cifl_pkg::BIT_M_DC]     = src_rise[0];
    end

    // Address decode
    assign sel_play_sticky = (reg_addr_in == cifl_pkg::ADDR_PLAY_STICKY);
    assign sel_rec_sticky  = (reg_addr_in == cifl_pkg::ADDR_REC_STICKY);
    assign sel_rec_status  = (reg_addr_in == cifl_pkg::ADDR_REC_STATUS);
    assign sel_ctrl1       = (reg_addr_in == cifl_pkg::ADDR_IRQ1_CTRL);
    assign sel_ctrl2       = (reg_addr_in == cifl_pkg::ADDR_IRQ2_CTRL);
    assign rd_play_sticky  = reg_read_in && sel_play_sticky;
    assign rd_rec_sticky   = reg_read_in && sel_rec_sticky;

    // Read clears, but a set in the same cycle wins so no event is lost
    assign next_play_sticky = (rd_play_sticky ? 8'h00 : play_sticky) | play_set;
    assign next_rec_sticky  = (rd_rec_sticky ? 8'h00 : rec_sticky) | rec_set;

    // Both sticky registers must be read before repeated pulses stop
    assign both_read = (read_play_seen || rd_play_sticky)
                    && (read_rec_seen || rd_rec_sticky);

    // Read mux; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr_in)
            cifl_pkg::ADDR_PLAY_STICKY: next_rdata = play_sticky;
            cifl_pkg::ADDR_REC_STICKY:  next_rdata = rec_sticky;
            cifl_pkg::ADDR_PLAY_STATUS: next_rdata = playback_event_status;
            cifl_pkg::ADDR_REC_STATUS:  next_rdata = record_event_status;
            cifl_pkg::ADDR_IRQ1_CTRL:   next_rdata = first_irq_mask_control;
            cifl_pkg::ADDR_IRQ2_CTRL:   next_rdata = second_irq_mask_control;
            default:                    next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_read_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // Writable registers; the reserved control bit is never stored
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            first_irq_mask_control  <= cifl_pkg::CTRL_RESET;
            second_irq_mask_control <= cifl_pkg::CTRL_RESET;
            record_rsvd             <= cifl_pkg::REC_RSVD_RESET;
        end else if (reg_write_in) begin
            if (sel_ctrl1) begin
                first_irq_mask_control <= reg_wdata_in & cifl_pkg::CTRL_WR_MASK;
            end
            if (sel_ctrl2) begin
                second_irq_mask_control <= reg_wdata_in & cifl_pkg::CTRL_WR_MASK;
            end
            if (sel_rec_status) begin
                record_rsvd <= reg_wdata_in & cifl_pkg::REC_WR_MASK;
            end
        end
    end

    // Sticky flags and read tracking
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            play_sticky    <= cifl_pkg::STICKY_RESET;
            rec_sticky     <= cifl_pkg::STICKY_RESET;
            prev_src       <= 8'h00;
            read_play_seen <= 1'b0;
            read_rec_seen  <= 1'b0;
        end else begin
            play_sticky <= next_play_sticky;
            rec_sticky  <= next_rec_sticky;
            prev_src    <= src;
            if (both_read || trigger1 || trigger2) begin
                read_play_seen <= 1'b0;
                read_rec_seen  <= 1'b0;
            end else begin
                read_play_seen <= read_play_seen || rd_play_sticky;
                read_rec_seen  <= read_rec_seen || rd_rec_sticky;
            end
        end
    end

    // Only enabled events start a pulse train
    assign trigger1 = masked_any(first_irq_mask_control, events);
    assign trigger2 = masked_any(second_irq_mask_control, events);

    cifl_tick_divider #(
        .CYCLES (CYCLES_PER_TICK)
    ) u_tick (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .tick_out  (tick)
    );

    cifl_pulse_gen u_first (
        .clock_in   (clock_in),
        .resetn_in  (resetn_in),
        .tick_in    (tick),
        .trigger_in (trigger1),
        .repeat_in  (first_irq_mask_control[cifl_pkg::BIT_M_REPEAT]),
        .ack_in     (both_read),
        .pulse_out  (first_irq_output_out)
    );

    cifl_pulse_gen u_second (
        .clock_in   (clock_in),
        .resetn_in  (resetn_in),
        .tick_in    (tick),
        .trigger_in (trigger2),
        .repeat_in  (second_irq_mask_control[cifl_pkg::BIT_M_REPEAT]),
        .ack_in     (both_read),
        .pulse_out  (second_irq_output_out)
    );
endmodule

// ==== hdl/cifl_pkg.sv ====
// Constants shared by the codec interrupt flag logic
package cifl_pkg;
    // Register offsets on the control port
    localparam logic [7:0] ADDR_PLAY_STICKY = 8'h2C;
    localparam logic [7:0] ADDR_REC_STICKY  = 8'h2D;
    localparam logic [7:0] ADDR_PLAY_STATUS = 8'h2E;
    localparam logic [7:0] ADDR_REC_STATUS  = 8'h2F;
    localparam logic [7:0] ADDR_IRQ1_CTRL   = 8'h30;
    localparam logic [7:0] ADDR_IRQ2_CTRL   = 8'h31;

    // Playback status and sticky field positions
    localparam int BIT_SHORT_LEFT  = 7;
    localparam int BIT_SHORT_RIGHT = 6;
    localparam int BIT_BUTTON      = 5;
    localparam int BIT_HEADSET     = 4;
    localparam int BIT_POWER_LEFT  = 3;
    localparam int BIT_POWER_RIGHT = 2;
    // Record status field positions
    localparam int BIT_NOISE       = 6;
    localparam int BIT_DC_AVAIL    = 2;
    // Mask control field positions
    localparam int BIT_M_INSERT    = 7;
    localparam int BIT_M_BUTTON    = 6;
    localparam int BIT_M_POWER     = 5;
    localparam int BIT_M_NOISE     = 4;
    localparam int BIT_M_SHORT     = 3;
    localparam int BIT_M_RSVD      = 2;
    localparam int BIT_M_DC        = 1;
    localparam int BIT_M_REPEAT    = 0;

    // Writable bits and reset values
    localparam logic [7:0] CTRL_WR_MASK   = 8'hFB;
    localparam logic [7:0] REC_WR_MASK    = 8'hA3;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] REC_RSVD_RESET = 8'h00;
    localparam logic [7:0] STICKY_RESET   = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS    = 4;
    localparam int TICK_NS          = 1000;
    localparam int PULSE_WIDTH_US   = 2000;
    localparam int PULSE_PERIOD_US  = 4000;
    localparam int CYCLES_PER_TICK  = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_HIGH_TICKS = PULSE_WIDTH_US * 1000 / TICK_NS;
    localparam int PULSE_LOW_TICKS  = (PULSE_PERIOD_US - PULSE_WIDTH_US) * 1000 / TICK_NS;
endpackage

// ==== hdl/cifl_tick_divider.sv ====
// Divider giving a one-cycle tick every microsecond
`timescale 1ns/1ns
module cifl_tick_divider #(
    parameter int CYCLES = cifl_pkg::CYCLES_PER_TICK
) (
    input  wire logic clock_in,
    input  wire logic resetn_in,
    output logic      tick_out
);
    logic [15:0] count;
    logic        at_end;

    assign at_end = (count == 16'(CYCLES - 1));

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            count    <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            count    <= at_end ? 16'h0000 : count + 16'h0001;
            tick_out <= at_end;
        end
    end
endmodule

// ==== hdl/cifl_pulse_gen.sv ====
// Single or repeated pulse generator for one interrupt output
`timescale 1ns/1ns
module cifl_pulse_gen #(
    parameter int HIGH_TICKS = cifl_pkg::PULSE_HIGH_TICKS,
    parameter int LOW_TICKS  = cifl_pkg::PULSE_LOW_TICKS
) (
    input  wire logic clock_in,
    input  wire logic resetn_in,
    input  wire logic tick_in,
    input  wire logic trigger_in,
    input  wire logic repeat_in,
    input  wire logic ack_in,
    output logic      pulse_out
);
    typedef enum logic [1:0] {IDLE, HIGH, LOW} cifl_pulse_state_t;

    cifl_pulse_state_t state;
    logic [15:0]       count;
    logic              acked;
    logic              high_done;
    logic              low_done;

    assign high_done = tick_in && (count == 16'(HIGH_TICKS - 1));
    assign low_done  = tick_in && (count == 16'(LOW_TICKS - 1));

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state     <= IDLE;
            count     <= 16'h0000;
            acked     <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            if (tick_in) begin
                count <= count + 16'h0001;
            end
            acked <= ack_in || (acked && state != IDLE);
            unique case (state)
                IDLE: begin
                    if (trigger_in) begin
                        state     <= HIGH;
                        count     <= 16'h0000;
                        acked     <= 1'b0;
                        pulse_out <= 1'b1;
                    end
                end
                HIGH: begin
                    if (high_done) begin
                        state     <= LOW;
                        count     <= 16'h0000;
                        pulse_out <= 1'b0;
                    end
                end
                LOW: begin
                    // Reads stop the train when the current pulse ends, or at once during the low phase
                    if (!repeat_in || acked || ack_in) begin
                        state <= IDLE;
                    end else if (low_done) begin
                        state     <= HIGH;
                        count     <= 16'h0000;
                        pulse_out <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule

// ==== verif/cifl_core_asserts.sv ====
// Port-level checks for the codec interrupt flag logic
`timescale 1ns/1ns
module cifl_core_asserts #(
    parameter int CYCLES_PER_TICK = cifl_pkg::CYCLES_PER_TICK
) (
    input wire logic       clock_in,
    input wire logic       resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_write_in,
    input wire logic       reg_read_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       short_left_in,
    input wire logic       short_right_in,
    input wire logic       button_in,
    input wire logic       headset_in,
    input wire logic       power_left_in,
    input wire logic       power_right_in,
    input wire logic       noise_low_in,
    input wire logic       dc_avail_in,
    input wire logic       first_irq_output_out,
    input wire logic       second_irq_output_out
);
    localparam int HI = cifl_pkg::PULSE_HIGH_TICKS * CYCLES_PER_TICK;
    localparam int LO = cifl_pkg::PULSE_LOW_TICKS * CYCLES_PER_TICK;
    wire logic [7:0] src = {short_left_in, short_right_in, button_in, headset_in,
                            power_left_in, power_right_in, noise_low_in, dc_avail_in};
    wire logic rd_play = reg_read_in && reg_addr_in == cifl_pkg::ADDR_PLAY_STATUS;
    wire logic rd_rec  = reg_read_in && reg_addr_in == cifl_pkg::ADDR_REC_STATUS;
    wire logic rd_stk  = reg_read_in && reg_addr_in == cifl_pkg::ADDR_PLAY_STICKY;
    wire logic rd_ctl  = reg_read_in && reg_addr_in[7:1] == 7'h18;
    logic [7:0]  m1, m2;
    logic [31:0] hc1, hc2, lc1, lc2;
    // Low counters saturate so a first pulse after reset never looks early
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            m1 <= 8'h00;
            m2 <= 8'h00;
            hc1 <= 32'h0000_0000;
            hc2 <= 32'h0000_0000;
            lc1 <= 32'hFFFF_FFFF;
            lc2 <= 32'hFFFF_FFFF;
        end else begin
            if (reg_write_in && reg_addr_in == cifl_pkg::ADDR_IRQ1_CTRL) m1 <= reg_wdata_in;
            if (reg_write_in && reg_addr_in == cifl_pkg::ADDR_IRQ2_CTRL) m2 <= reg_wdata_in;
            hc1 <= first_irq_output_out ? hc1 + 32'h0000_0001 : 32'h0000_0000;
            hc2 <= second_irq_output_out ? hc2 + 32'h0000_0001 : 32'h0000_0000;
            lc1 <= first_irq_output_out ? 32'h0000_0000 : (&lc1 ? lc1 : lc1 + 32'h0000_0001);
            lc2 <= second_irq_output_out ? 32'h0000_0000 : (&lc2 ? lc2 : lc2 + 32'h0000_0001);
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    a_play_live: assert property (rd_play && $stable(src)
        |=> reg_rdata_out == {$past(src[7:2]), 2'b00})
        else $error("playback status differs from sources");
    // Bits 7, 5, 1 and 0 are writable reserved storage, so only the live and read-zero bits are compared
    a_rec_live: assert property (rd_rec && $stable(src)
        |=> {reg_rdata_out[6], reg_rdata_out[4:2]} == {$past(src[1]), 2'b00, $past(src[0])})
        else $error("record status differs from sources");
    a_ctrl_store: assert property (rd_ctl |=> reg_rdata_out == ($past(reg_addr_in[0] ? m2 : m1) & 8'hFB))
        else $error("mask control readback wrong");
    a_irq1_masked: assert property ($rose(first_irq_output_out) |-> $past(m1 & 8'hFA) != 8'h00)
        else $error("first output pulsed with no source enabled");
    a_irq2_masked: assert property ($rose(second_irq_output_out) |-> $past(m2 & 8'hFA) != 8'h00)
        else $error("second output pulsed with no source enabled");
    a_irq1_width: assert property ($fell(first_irq_output_out) |-> hc1 >= HI - CYCLES_PER_TICK && hc1 <= HI)
        else $error("first output pulse width wrong");
    a_irq2_width: assert property ($fell(second_irq_output_out) |-> hc2 >= HI - CYCLES_PER_TICK && hc2 <= HI)
        else $error("second output pulse width wrong");
    a_irq1_gap: assert property ($rose(first_irq_output_out) |-> lc1 >= LO - CYCLES_PER_TICK)
        else $error("first output repeated too soon");
    a_irq2_gap: assert property ($rose(second_irq_output_out) |-> lc2 >= LO - CYCLES_PER_TICK)
        else $error("second output repeated too soon");
    a_sticky_clear: assert property ((src == 8'h00)[*3] ##0 rd_stk ##1 (rd_stk && src == 8'h00)
        |=> reg_rdata_out == 8'h00) else $error("sticky flags survived a read");
    c_rise1: cover property ($rose(first_irq_output_out));
    c_rise2: cover property ($rose(second_irq_output_out));
    c_train: cover property ($rose(first_irq_output_out) && lc1 < 16'h2000);
endmodule
bind cifl_core cifl_core_asserts #(.CYCLES_PER_TICK(CYCLES_PER_TICK)) u_cifl_core_asserts (
    .clock_in, .resetn_in, .reg_addr_in, .reg_write_in, .reg_read_in, .reg_wdata_in, .reg_rdata_out,
    .short_left_in, .short_right_in, .button_in, .headset_in, .power_left_in, .power_right_in,
    .noise_low_in, .dc_avail_in, .first_irq_output_out, .second_irq_output_out);

// ==== verif/cifl_host_model.sv ====
// Host processor model driving the control port
`timescale 1ns/1ns
module cifl_host_model (
    input  wire logic  clock_in,
    output logic [7:0] reg_addr_out,
    output logic       reg_write_out,
    output logic       reg_read_out,
    output logic [7:0] reg_wdata_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_write_out = 1'b0;
        reg_read_out = 1'b0;
        reg_wdata_out = 8'h00;
    end
    // Entered at a falling edge; the strobe stays up so reads can run back to back
    task automatic rd(input logic [7:0] a);
        reg_addr_out = a;
        reg_write_out = 1'b0;
        reg_read_out = 1'b1;
        @(negedge clock_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_out = a;
        reg_read_out = 1'b0;
        reg_write_out = 1'b1;
        reg_wdata_out = d & (a == cifl_pkg::ADDR_REC_STATUS ? 8'hFC : 8'hFB);
        @(negedge clock_in);
    endtask
    // Released lines flip so stale values never read as valid
    task automatic idle();
        reg_addr_out = ~reg_addr_out;
        reg_wdata_out = ~reg_wdata_out;
        reg_write_out = 1'b0;
        reg_read_out = 1'b0;
        @(negedge clock_in);
    endtask
endmodule

// ==== verif/cifl_core_bench.sv ====
// Self-checking bench for the codec interrupt flag logic
`timescale 1ns/1ns
module cifl_core_bench;
    localparam int CPT = 2;
    localparam int HI  = cifl_pkg::PULSE_HIGH_TICKS * CPT;
    localparam int LO  = cifl_pkg::PULSE_LOW_TICKS * CPT;
    logic        clock_in, resetn_in, wr, rd, irq1, irq2, rv, hs;
    logic [7:0]  addr, wdata, rdata, src, acc_p, acc_r, m;
    logic [31:0] lfsr;
    logic [15:0] q[$];
    logic [15:0] e;
    int          n_errors, cmp_count;
    int          mb[6] = '{7, 6, 5, 4, 3, 1};
    int          sb[6] = '{4, 5, 3, 1, 7, 0};
    cifl_core #(.CYCLES_PER_TICK(CPT)) u_cifl_core (.clock_in(clock_in), .resetn_in(resetn_in),
        .reg_addr_in(addr), .reg_write_in(wr), .reg_read_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .short_left_in(src[7]), .short_right_in(src[6]), .button_in(src[5]),
        .headset_in(src[4]), .power_left_in(src[3]), .power_right_in(src[2]), .noise_low_in(src[1]),
        .dc_avail_in(src[0]), .first_irq_output_out(irq1), .second_irq_output_out(irq2));
    cifl_host_model u_cifl_host_model (.clock_in(clock_in), .reg_addr_out(addr), .reg_write_out(wr),
        .reg_read_out(rd), .reg_wdata_out(wdata));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] y);
        cmp_count++;
        if (x !== y) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, x, y);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    // Read data is checked one cycle later by the monitor below
    task automatic rdx(input logic [7:0] a, input logic [7:0] x, input logic [7:0] k);
        q.push_back({k, x});
        u_cifl_host_model.rd(a);
    endtask
    task automatic lvl(input logic v, input int n);
        for (int k = 0; k < n && irq1 !== v; k++) cyc(1);
    endtask
    task automatic fire(input int s, input logic o1);
        int w;
        w = 0;
        src[s] = 1'b1;
        cyc(1);
        src[s] = 1'b0;
        cyc(2);
        chk("first output", {7'h00, o1}, {7'h00, irq1});
        chk("second output", {7'h00, !o1}, {7'h00, irq2});
        while ((irq1 | irq2) === 1'b1 && w < HI) begin
            cyc(1);
            w++;
        end
        chk("pulse width", 8'h01, {7'h00, w > HI - CPT - 4 && w < HI});
        cyc(LO + 100);
        chk("single pulse", 8'h00, {6'h00, irq1, irq2});
    endtask
    always @(posedge clock_in) rv <= rd;
    always @(negedge clock_in) begin
        if (rv) begin
            e = q.pop_front();
            chk("read data", e[7:0], rdata & e[15:8]);
        end
    end
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    initial begin
        #360000;
        n_errors++;
        final_report();
    end
    initial begin
        resetn_in = 1'b0;
        src = 8'h00;
        lfsr = 32'h369CF4C3;
        cyc(12);
        resetn_in = 1'b1;
        rdx(cifl_pkg::ADDR_PLAY_STATUS, 8'h00, 8'hFF);
        rdx(cifl_pkg::ADDR_REC_STATUS, 8'h00, 8'hFF);
        rdx(cifl_pkg::ADDR_IRQ1_CTRL, 8'h00, 8'hFF);
        rdx(cifl_pkg::ADDR_IRQ2_CTRL, 8'h00, 8'hFF);
        rdx(cifl_pkg::ADDR_PLAY_STICKY, 8'h00, 8'hFF);
        rdx(8'h40, 8'h00, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            u_cifl_host_model.wr(cifl_pkg::ADDR_IRQ1_CTRL, lfsr[7:0]);
            u_cifl_host_model.wr(cifl_pkg::ADDR_IRQ2_CTRL, lfsr[15:8]);
            u_cifl_host_model.wr(cifl_pkg::ADDR_REC_STATUS, lfsr[23:16]);
            rdx(cifl_pkg::ADDR_IRQ1_CTRL, lfsr[7:0] & 8'hFB, 8'hFF);
            rdx(cifl_pkg::ADDR_IRQ2_CTRL, lfsr[15:8] & 8'hFB, 8'hFF);
            rdx(cifl_pkg::ADDR_REC_STATUS, lfsr[23:16] & 8'hA0, 8'hA0);
        end
        u_cifl_host_model.wr(cifl_pkg::ADDR_IRQ1_CTRL, 8'h00);
        u_cifl_host_model.wr(cifl_pkg::ADDR_IRQ2_CTRL, 8'h00);
        hs = 1'b0;
        acc_p = 8'h00;
        acc_r = 8'h00;
        for (int i = 0; i <= 6; i++) begin
            lfsr = nxt(lfsr);
            src = (i == 6) ? 8'h00 : lfsr[7:0];
            acc_p |= {src[7:5], src[4] ^ hs, src[3:2], 2'b00};
            acc_r |= {1'b0, src[1], 3'b000, src[0], 2'b00};
            hs = src[4];
            u_cifl_host_model.idle();
            cyc(3);
            rdx(cifl_pkg::ADDR_PLAY_STATUS, {src[7:2], 2'b00}, 8'hFF);
            rdx(cifl_pkg::ADDR_REC_STATUS, {1'b0, src[1], 3'b000, src[0], 2'b00}, 8'h5F);
        end
        rdx(cifl_pkg::ADDR_PLAY_STICKY, acc_p, 8'hFF);
        rdx(cifl_pkg::ADDR_PLAY_STICKY, 8'h00, 8'hFF);
        rdx(cifl_pkg::ADDR_REC_STICKY, acc_r, 8'h44);
        rdx(cifl_pkg::ADDR_REC_STICKY, 8'h00, 8'h44);
        for (int i = 0; i < 6; i++) begin
            m = 8'h01 << mb[i];
            u_cifl_host_model.wr(cifl_pkg::ADDR_IRQ1_CTRL, i[0] ? ~m & 8'hFA : m);
            u_cifl_host_model.wr(cifl_pkg::ADDR_IRQ2_CTRL, i[0] ? m : ~m & 8'hFA);
            u_cifl_host_model.idle();
            fire(sb[i], !i[0]);
        end
        rdx(cifl_pkg::ADDR_PLAY_STICKY, 8'h00, 8'h00);
        rdx(cifl_pkg::ADDR_REC_STICKY, 8'h00, 8'h00);
        u_cifl_host_model.wr(cifl_pkg::ADDR_IRQ2_CTRL, 8'h41);
        u_cifl_host_model.wr(cifl_pkg::ADDR_IRQ1_CTRL, 8'h41);
        u_cifl_host_model.idle();
        src[5] = 1'b1;
        cyc(1);
        src[5] = 1'b0;
        lvl(1'b1, 4);
        rdx(cifl_pkg::ADDR_PLAY_STICKY, 8'h20, 8'hFF);
        u_cifl_host_model.idle();
        lvl(1'b0, HI);
        lvl(1'b1, LO + 100);
        chk("repeat pulse", 8'h03, {6'h00, irq1, irq2});
        rdx(cifl_pkg::ADDR_REC_STICKY, 8'h00, 8'h44);
        rdx(cifl_pkg::ADDR_PLAY_STICKY, 8'h00, 8'hFF);
        u_cifl_host_model.idle();
        lvl(1'b0, HI);
        cyc(LO + 100);
        chk("train stopped", 8'h00, {6'h00, irq1, irq2});
        final_report();
    end
endmodule
